// file: sbc_charge_fsm.sv
/*
  Smart-battery charge state machine with AXI4-Lite register slave.
  Assumes pins (safety decode, input sense, voltage comparators) are
  asynchronous and come from the analog front end; one clock, clk.
*/
// Added by the designer: the placing of the registers and the AXI4-Lite slave port.
// Summary of operation
// - wake-up charge drives a fixed current, ignoring stored requests.
// - wake-up current equals preconditioning current; precondition uses that limit.
// - wake-up timer runs the watchdog period of 175 seconds.
// - wake-up starts without requests, input present, battery present, safety not hot.
// - wake-up timeout while cold or under-range goes off, no fault flag.
// - hot reading in any charge state goes off.
// - over-range reading goes to reset from charge states and off.
// - input loss enters reset; wake-up resumes once input returns.
// - wake-up moves to precondition once both requests written non-zero.
// - alarm block flag set during charge goes off.
// - charge inhibit halts charging; active timer keeps running.
// - calibration start moves to calibration from wake, precondition, bulk, off.
// - zero written to either request during charge goes off.
// - zero-requests bit stops charging and goes off.
// - precondition held by one request pair; watchdog inactive there.
// - precondition enters bulk when battery exceeds bulk threshold.
// - quarter timer expiry in precondition goes off.
// - bulk uses bulk current; entry needs requests, safety, input.
// - bulk needs both requests rewritten each watchdog period, else off.
// - stored request values are never read back.
// - off state disallows all charging regardless of thermistor.
// - off enters precondition with requests, safe reading, inhibit clear.
// - overvoltage pauses charging until hysteresis, timers run, no fault.
`timescale 1ns/1ps
module sbc_charge_fsm (
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  input  wire sbc_pkg::sbc_safety_t safety_pin,
  input  wire logic                 input_sense_divided,
  input  wire logic                 input_supply,
  input  wire logic                 battery_above_bulk,
  input  wire logic                 battery_overvoltage,
  input  wire logic                 battery_below_hyst,
  output sbc_pkg::sbc_drive_t       drive,
  output logic                      charge_fault_flag,
  output logic                      alarm_block_flag,
  output logic [2:0]                charge_state,
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready
);

  // ==========================================================
  // pin synchronisers
  localparam int NSYNC = 9;
  logic [NSYNC-1:0] sync_a;
  logic [NSYNC-1:0] sync_b;
  logic [NSYNC-1:0] pins;
  assign pins = {safety_pin, input_sense_divided, input_supply,
                 battery_above_bulk, battery_overvoltage};
  // hysteresis comparator is folded into the overvoltage latch below
  logic hyst_a;
  logic hyst_b;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync_a <= '0;
      sync_b <= '0;
      hyst_a <= 1'b0;
      hyst_b <= 1'b0;
    end else begin
      sync_a <= pins;
      sync_b <= sync_a;
      hyst_a <= battery_below_hyst;
      hyst_b <= hyst_a;
    end
  end

  sbc_pkg::sbc_safety_t safety;
  logic input_ok;
  logic above_bulk;
  logic over_v;
  assign safety     = sync_b[8:4];
  assign input_ok   = sync_b[3] && sync_b[2];
  assign above_bulk = sync_b[1];
  assign over_v     = sync_b[0];

  logic safe_to_charge;
  assign safe_to_charge = (safety.cold || safety.ideal || safety.under_range) && !safety.hot
                          && !safety.over_range;

  // ==========================================================
  // axi4-lite slave: single outstanding write and read
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        wr_fire;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign wr_fire       = aw_held && w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end

  logic addr_known;
  assign addr_known = aw_addr inside {sbc_pkg::ADDR_CONTROL, sbc_pkg::ADDR_STATUS,
                      sbc_pkg::ADDR_CHG_VOLTAGE, sbc_pkg::ADDR_CHG_CURRENT,
                      sbc_pkg::ADDR_ALARM};

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= sbc_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= addr_known ? sbc_pkg::RESP_OKAY : sbc_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // request writes: the value is kept only as a nonzero flag
  logic wr_volt;
  logic wr_curr;
  logic wr_ctl;
  logic wr_alarm;
  logic [15:0] wr_word;
  assign wr_word  = w_data[15:0];
  assign wr_volt  = wr_fire && aw_addr == sbc_pkg::ADDR_CHG_VOLTAGE && w_strb[1:0] == 2'h3;
  assign wr_curr  = wr_fire && aw_addr == sbc_pkg::ADDR_CHG_CURRENT && w_strb[1:0] == 2'h3;
  assign wr_ctl   = wr_fire && aw_addr == sbc_pkg::ADDR_CONTROL && w_strb[0];
  assign wr_alarm = wr_fire && aw_addr == sbc_pkg::ADDR_ALARM && w_strb[1:0] == 2'h3;

  logic zero_write;
  assign zero_write = (wr_volt || wr_curr) && wr_word == 16'h0000;

  // ==========================================================
  // control register
  logic [sbc_pkg::CTL_WIDTH-1:0] control;
  logic charge_inhibit;
  logic zero_requests_bit;
  logic cal_start;
  assign charge_inhibit    = control[sbc_pkg::CTL_INHIBIT];
  assign zero_requests_bit = control[sbc_pkg::CTL_ZERO_REQ];
  assign cal_start         = control[sbc_pkg::CTL_CAL];

  sbc_pkg::sbc_state_t state;
  sbc_pkg::sbc_state_t next_state;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      control <= sbc_pkg::CTL_RESET;
    end else if (wr_ctl) begin
      control <= w_data[sbc_pkg::CTL_WIDTH-1:0];
    end else if (state == sbc_pkg::SBC_RESET) begin
      // reset state clears the host inhibit, as on power-on
      control[sbc_pkg::CTL_INHIBIT] <= 1'b0;
    end
  end

  // ==========================================================
  // request tracking
  logic volt_nz;
  logic curr_nz;
  logic volt_fresh;
  logic curr_fresh;
  logic requests_ok;
  assign requests_ok = volt_nz && curr_nz;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      volt_nz <= 1'b0;
      curr_nz <= 1'b0;
    end else if (zero_requests_bit || state == sbc_pkg::SBC_RESET) begin
      volt_nz <= 1'b0;
      curr_nz <= 1'b0;
    end else begin
      if (wr_volt) volt_nz <= wr_word != 16'h0000;
      if (wr_curr) curr_nz <= wr_word != 16'h0000;
    end
  end

  // ==========================================================
  // timebase and timers
  logic [$clog2(sbc_pkg::TICK_DIV)-1:0]       prescale;
  logic                                       tick;
  logic [$clog2(sbc_pkg::WATCHDOG_TICKS)-1:0] timer;
  logic                                       timer_done;
  logic                                       rewrite_pair;
  assign tick = prescale == ($clog2(sbc_pkg::TICK_DIV))'(sbc_pkg::TICK_DIV - 1);
  assign rewrite_pair = volt_fresh && curr_fresh;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prescale <= '0;
    end else begin
      prescale <= tick ? '0 : prescale + 1'b1;
    end
  end

  always_comb begin
    unique case (state)
      sbc_pkg::SBC_PRECOND:
        timer_done = timer == ($bits(timer))'(sbc_pkg::QUARTER_TICKS - 1);
      sbc_pkg::SBC_WAKE, sbc_pkg::SBC_BULK:
        timer_done = timer == ($bits(timer))'(sbc_pkg::WATCHDOG_TICKS - 1);
      default:
        timer_done = 1'b0;
    endcase
  end

  // timer restarts on any state change; inhibit does not pause it
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      timer <= '0;
    end else if (next_state != state) begin
      timer <= '0;
    end else if (state == sbc_pkg::SBC_BULK && rewrite_pair) begin
      timer <= '0;
    end else if (tick && !timer_done) begin
      timer <= timer + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      volt_fresh <= 1'b0;
      curr_fresh <= 1'b0;
    end else if (rewrite_pair || state != sbc_pkg::SBC_BULK) begin
      volt_fresh <= 1'b0;
      curr_fresh <= 1'b0;
    end else begin
      if (wr_volt) volt_fresh <= 1'b1;
      if (wr_curr) curr_fresh <= 1'b1;
    end
  end

  // ==========================================================
  // state machine
  logic charging_state;
  assign charging_state = state inside {sbc_pkg::SBC_WAKE, sbc_pkg::SBC_PRECOND,
                                        sbc_pkg::SBC_BULK};

  always_comb begin
    next_state = state;
    unique case (state)
      sbc_pkg::SBC_RESET: begin
        if (input_ok && !safety.over_range && safe_to_charge && !alarm_block_flag)
          next_state = requests_ok ? sbc_pkg::SBC_PRECOND : sbc_pkg::SBC_WAKE;
      end
      sbc_pkg::SBC_OFF: begin
        if (safety.over_range || !input_ok)
          next_state = sbc_pkg::SBC_RESET;
        else if (cal_start)
          next_state = sbc_pkg::SBC_CAL;
        else if (requests_ok && safe_to_charge && !charge_inhibit && !zero_requests_bit
                 && !alarm_block_flag)
          next_state = sbc_pkg::SBC_PRECOND;
      end
      sbc_pkg::SBC_CAL: begin
        if (!cal_start)
          next_state = sbc_pkg::SBC_OFF;
      end
      default: begin
        // charge states share their exit priority
        if (safety.over_range || !input_ok)
          next_state = sbc_pkg::SBC_RESET;
        else if (cal_start)
          next_state = sbc_pkg::SBC_CAL;
        else if (safety.hot || alarm_block_flag || zero_write || zero_requests_bit)
          next_state = sbc_pkg::SBC_OFF;
        else if (state == sbc_pkg::SBC_WAKE && requests_ok)
          next_state = sbc_pkg::SBC_PRECOND;
        else if (state == sbc_pkg::SBC_WAKE && timer_done)
          next_state = sbc_pkg::SBC_OFF;
        else if (state == sbc_pkg::SBC_PRECOND && above_bulk && requests_ok)
          next_state = sbc_pkg::SBC_BULK;
        else if (state == sbc_pkg::SBC_PRECOND && timer_done)
          next_state = sbc_pkg::SBC_OFF;
        else if (state == sbc_pkg::SBC_BULK && timer_done)
          next_state = sbc_pkg::SBC_OFF;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) state <= sbc_pkg::SBC_RESET;
    else          state <= next_state;
  end

  // alarm block: set by alarm write, cleared only by the reset state
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      alarm_block_flag <= 1'b0;
    end else if (wr_alarm && (wr_word & sbc_pkg::ALARM_MASK) != 16'h0000) begin
      alarm_block_flag <= 1'b1; // set wins over any clear
    end else if (state == sbc_pkg::SBC_RESET) begin
      alarm_block_flag <= 1'b0;
    end
  end

  // ==========================================================
  // overvoltage pause, no fault and no timer effect
  logic ov_pause;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n)                ov_pause <= 1'b0;
    else if (over_v)             ov_pause <= 1'b1;
    else if (hyst_b)             ov_pause <= 1'b0;
  end

  logic run;
  assign run = charging_state && !charge_inhibit && !ov_pause && !safety.hot;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      drive             <= '0;
      charge_fault_flag <= 1'b0;
      charge_state      <= 3'h0;
    end else begin
      // wake and precondition share the precondition current limit
      drive.precond_current <= run && state != sbc_pkg::SBC_BULK;
      drive.bulk_current    <= run && state == sbc_pkg::SBC_BULK;
      charge_fault_flag     <= charging_state && safety.hot && !safety.under_range;
      charge_state          <= 3'(state);
    end
  end

  // ==========================================================
  // read path; request values are write-only
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= sbc_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= sbc_pkg::RESP_OKAY;
      s_axi_rdata  <= 32'h0000_0000;
      unique case (s_axi_araddr)
        sbc_pkg::ADDR_CONTROL: s_axi_rdata <= 32'(control);
        sbc_pkg::ADDR_STATUS: begin
          s_axi_rdata[sbc_pkg::ST_STATE_LSB +: 3] <= 3'(state);
          s_axi_rdata[sbc_pkg::ST_FAULT]          <= charge_fault_flag;
          s_axi_rdata[sbc_pkg::ST_ALARM]          <= alarm_block_flag;
          s_axi_rdata[sbc_pkg::ST_INHIBIT]        <= charge_inhibit;
          s_axi_rdata[sbc_pkg::ST_CHARGING]       <= run;
          s_axi_rdata[sbc_pkg::ST_PRECOND_I]      <= drive.precond_current;
          s_axi_rdata[sbc_pkg::ST_BULK_I]         <= drive.bulk_current;
        end
        sbc_pkg::ADDR_CHG_VOLTAGE, sbc_pkg::ADDR_CHG_CURRENT, sbc_pkg::ADDR_ALARM: ;
        default: s_axi_rresp <= sbc_pkg::RESP_SLVERR;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================================
  // assertions
  sequence s_hot_in_charge;
    charging_state && safety.hot && !safety.over_range && input_ok && !cal_start;
  endsequence

  a_hot_goes_off: assert property (@(posedge clk) disable iff (!reset_n)
    s_hot_in_charge |=> state == sbc_pkg::SBC_OFF)
    else $error("hot reading did not reach off");

  a_removal_reset: assert property (@(posedge clk) disable iff (!reset_n)
    (state != sbc_pkg::SBC_CAL && safety.over_range) |=> state == sbc_pkg::SBC_RESET)
    else $error("over-range did not reach reset");

  a_input_loss_reset: assert property (@(posedge clk) disable iff (!reset_n)
    (charging_state && !input_ok) |=> state == sbc_pkg::SBC_RESET)
    else $error("input loss did not reach reset");

  a_off_no_drive: assert property (@(posedge clk) disable iff (!reset_n)
    (state == sbc_pkg::SBC_OFF) [*2] |-> drive == '0)
    else $error("current drive in off state");

  a_bulk_current: assert property (@(posedge clk) disable iff (!reset_n)
    drive.bulk_current |-> $past(state) == sbc_pkg::SBC_BULK && !drive.precond_current)
    else $error("bulk current outside bulk state");

  a_zero_write_off: assert property (@(posedge clk) disable iff (!reset_n)
    (charging_state && zero_write && input_ok && !safety.over_range && !cal_start)
    |=> state == sbc_pkg::SBC_OFF)
    else $error("zero request write did not reach off");

  a_wake_to_pre: assert property (@(posedge clk) disable iff (!reset_n)
    (state == sbc_pkg::SBC_WAKE && requests_ok && safe_to_charge && input_ok
     && !cal_start && !alarm_block_flag && !zero_write && !zero_requests_bit)
    |=> state == sbc_pkg::SBC_PRECOND)
    else $error("wake-up ignored request pair");

  a_inhibit_no_pause: assert property (@(posedge clk) disable iff (!reset_n)
    (charging_state && charge_inhibit && tick && !timer_done && next_state == state
     && !(state == sbc_pkg::SBC_BULK && rewrite_pair)) |=> timer == $past(timer) + 1'b1)
    else $error("timer paused during inhibit");

  a_ov_no_fault: assert property (@(posedge clk) disable iff (!reset_n)
    (ov_pause && !safety.hot) |=> !charge_fault_flag)
    else $error("overvoltage raised a fault");

endmodule

// file: sbc_pkg.sv
/*
  Package for the smart-battery charge state machine: register map,
  field positions, reset values, states and timing counts.
  Assumes a 20 MHz system clock and an AXI4-Lite register bus.
*/
package sbc_pkg;

  // ==========================================================
  // clock and timing
  localparam int unsigned CLK_HZ             = 20_000_000;
  localparam int unsigned TICK_HZ            = 1000;
  localparam int unsigned TICK_DIV           = CLK_HZ / TICK_HZ;
  localparam int unsigned WATCHDOG_SEC       = 175;
  localparam int unsigned WATCHDOG_TICKS     = WATCHDOG_SEC * TICK_HZ;
  localparam int unsigned QUARTER_TICKS      = WATCHDOG_TICKS / 4;

  // ==========================================================
  // register byte addresses
  localparam logic [7:0] ADDR_CONTROL     = 8'h00;
  localparam logic [7:0] ADDR_STATUS      = 8'h04;
  localparam logic [7:0] ADDR_CHG_VOLTAGE = 8'h08;
  localparam logic [7:0] ADDR_CHG_CURRENT = 8'h0C;
  localparam logic [7:0] ADDR_ALARM       = 8'h10;

  // control fields (backup_control_reg)
  localparam int CTL_INHIBIT  = 0;
  localparam int CTL_ZERO_REQ = 1;
  localparam int CTL_CAL      = 2;
  localparam int CTL_WIDTH    = 3;
  localparam logic [CTL_WIDTH-1:0] CTL_RESET = 3'h0;

  // status fields
  localparam int ST_STATE_LSB = 0;
  localparam int ST_FAULT     = 3;
  localparam int ST_ALARM     = 4;
  localparam int ST_INHIBIT   = 5;
  localparam int ST_CHARGING  = 6;
  localparam int ST_PRECOND_I = 7;
  localparam int ST_BULK_I    = 8;

  // alarm write: any set bit within ALARM_MASK blocks charging until reset
  localparam logic [15:0] ALARM_MASK = 16'hD800;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // types
  typedef enum logic [2:0] {
    SBC_RESET, SBC_WAKE, SBC_PRECOND, SBC_BULK, SBC_OFF, SBC_CAL
  } sbc_state_t;

  typedef struct packed {
    logic cold;
    logic ideal;
    logic under_range;
    logic hot;
    logic over_range;
  } sbc_safety_t;

  typedef struct packed {
    logic precond_current;
    logic bulk_current;
  } sbc_drive_t;

endpackage

// file: sbc_batt_model.sv
/*
  Far-side model: battery pack, thermistor decoder and input sensing
  as seen at the charger pins. Assumes the bench selects the levels.
*/
`timescale 1ns/1ps
module sbc_batt_model (
  input  wire logic [2:0]      temp_sel,
  input  wire logic            dc_ok,
  input  wire logic            uvlo_ok,
  input  wire logic            v_bulk,
  input  wire logic            v_over,
  output sbc_pkg::sbc_safety_t safety_pin,
  output logic                 input_sense_divided,
  output logic                 input_supply,
  output logic                 battery_above_bulk,
  output logic                 battery_overvoltage,
  output logic                 battery_below_hyst
);
  // ==========================================================
  // pins
  // one decoded level at a time; code 4 is an open thermistor, no pack
  assign safety_pin          = sbc_pkg::sbc_safety_t'(5'h10 >> temp_sel);
  assign input_sense_divided = dc_ok;
  assign input_supply        = uvlo_ok;
  assign battery_above_bulk  = v_bulk;
  assign battery_overvoltage = v_over;
  // hysteresis sits at the overvoltage level itself, the inverse of v_over
  assign battery_below_hyst  = !v_over;
endmodule

// file: smart_battery_charge_fsm_bench.sv
/*
  Self-checking bench for the charge state machine: AXI4-Lite tasks,
  pin control through the battery model. Assumes sbc_pkg compiled first.
*/
`timescale 1ns/1ps
module smart_battery_charge_fsm_bench;
  logic                 clk;
  logic                 reset_n;
  logic [2:0]           temp_sel;
  logic                 dc_ok, uvlo_ok, v_bulk, v_over;
  sbc_pkg::sbc_safety_t safety_pin;
  logic                 sense, supply, above_bulk, over_v, below_hyst;
  sbc_pkg::sbc_drive_t  drive;
  logic                 fault, alarm;
  logic [2:0]           charge_state;
  logic [7:0]           awaddr, araddr;
  logic [31:0]          wdata, rdata, rd;
  logic [3:0]           wstrb;
  logic                 awvalid, awready, wvalid, wready, bvalid, bready;
  logic                 arvalid, arready, rvalid, rready;
  logic [1:0]           bresp, rresp, resp;
  int                   n_mismatch, checked;

  sbc_batt_model model (.temp_sel(temp_sel), .dc_ok(dc_ok), .uvlo_ok(uvlo_ok),
    .v_bulk(v_bulk), .v_over(v_over), .safety_pin(safety_pin),
    .input_sense_divided(sense), .input_supply(supply), .battery_above_bulk(above_bulk),
    .battery_overvoltage(over_v), .battery_below_hyst(below_hyst));

  sbc_charge_fsm dut (.clk(clk), .reset_n(reset_n), .safety_pin(safety_pin),
    .input_sense_divided(sense), .input_supply(supply), .battery_above_bulk(above_bulk),
    .battery_overvoltage(over_v), .battery_below_hyst(below_hyst), .drive(drive),
    .charge_fault_flag(fault), .alarm_block_flag(alarm), .charge_state(charge_state),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  // ==========================================================
  // tasks
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  // ready is sampled a half cycle early: inputs only move on rising edges
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic da, dw, ta, tw;
    da = 1'b0;
    dw = 1'b0;
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!(da && dw)) begin
      @(negedge clk);
      ta = awready && !da;
      tw = wready && !dw;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      da = da || ta;
      dw = dw || tw;
    end
    do begin
      @(negedge clk);
      ta   = bvalid;
      resp = bresp;
      @(posedge clk);
    end while (!ta);
    bready <= 1'b0;
  endtask

  task automatic rdw(input logic [7:0] a);
    logic t;
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(negedge clk);
      t = arready;
      @(posedge clk);
    end while (!t);
    arvalid <= 1'b0;
    do begin
      @(negedge clk);
      t    = rvalid;
      rd   = rdata;
      resp = rresp;
      @(posedge clk);
    end while (!t);
    rready <= 1'b0;
  endtask

  task automatic pin(input logic [2:0] t, input logic dc, input logic uv,
                     input logic bk, input logic ov);
    @(posedge clk);
    temp_sel <= t;
    dc_ok    <= dc;
    uvlo_ok  <= uv;
    v_bulk   <= bk;
    v_over   <= ov;
  endtask

  // pins need three clocks, the state code one more
  task automatic st(input sbc_pkg::sbc_state_t s, input logic [1:0] dr);
    repeat (6) @(posedge clk);
    @(negedge clk);
    chk("charge_state", 32'(charge_state), 32'(s));
    chk("drive", 32'(drive), 32'(dr));
  endtask

  task automatic req();
    wr(sbc_pkg::ADDR_CHG_VOLTAGE, 32'h0000_3000);
    wr(sbc_pkg::ADDR_CHG_CURRENT, 32'h0000_0800);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // ==========================================================
  // clock, watchdog, tests
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial begin
    #(50 * 40000);
    n_mismatch++;
    results();
  end

  initial begin
    {temp_sel, dc_ok, uvlo_ok, v_bulk, v_over} = {3'h1, 4'h4};
    {awaddr, araddr, wdata, wstrb} = {16'h0, 32'h0, 4'hF};
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    reset_n = 1'b0;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    st(sbc_pkg::SBC_RESET, 2'b00);
    pin(3'h0, 1'b1, 1'b1, 1'b0, 1'b0);
    st(sbc_pkg::SBC_WAKE, 2'b10);
    rdw(sbc_pkg::ADDR_CHG_VOLTAGE);
    chk("voltage_readback", rd, 32'h0);
    rdw(8'h14);
    chk("rresp_unmapped", 32'(resp), 32'(sbc_pkg::RESP_SLVERR));
    wr(8'h14, 32'h1);
    chk("bresp_unmapped", 32'(resp), 32'(sbc_pkg::RESP_SLVERR));
    wr(sbc_pkg::ADDR_CHG_VOLTAGE, 32'h0000_3000);
    chk("bresp", 32'(resp), 32'(sbc_pkg::RESP_OKAY));
    st(sbc_pkg::SBC_WAKE, 2'b10);
    wr(sbc_pkg::ADDR_CHG_CURRENT, 32'h0000_0800);
    st(sbc_pkg::SBC_PRECOND, 2'b10);
    rdw(sbc_pkg::ADDR_CHG_CURRENT);
    chk("current_readback", rd, 32'h0);
    rdw(sbc_pkg::ADDR_STATUS);
    chk("status_state", 32'(rd[2:0]), 32'(sbc_pkg::SBC_PRECOND));
    wr(sbc_pkg::ADDR_CONTROL, 32'h1);
    st(sbc_pkg::SBC_PRECOND, 2'b00);
    // hold inhibit across a timebase tick so the timer is seen to advance
    repeat (sbc_pkg::TICK_DIV) @(posedge clk);
    st(sbc_pkg::SBC_PRECOND, 2'b00);
    wr(sbc_pkg::ADDR_CONTROL, 32'h0);
    st(sbc_pkg::SBC_PRECOND, 2'b10);
    pin(3'h0, 1'b1, 1'b1, 1'b1, 1'b0);
    st(sbc_pkg::SBC_BULK, 2'b01);
    req();
    st(sbc_pkg::SBC_BULK, 2'b01);
    pin(3'h0, 1'b1, 1'b1, 1'b1, 1'b1);
    st(sbc_pkg::SBC_BULK, 2'b00);
    pin(3'h0, 1'b1, 1'b1, 1'b1, 1'b0);
    st(sbc_pkg::SBC_BULK, 2'b01);
    pin(3'h1, 1'b1, 1'b1, 1'b0, 1'b0);
    wr(sbc_pkg::ADDR_CHG_CURRENT, 32'h0);
    st(sbc_pkg::SBC_OFF, 2'b00);
    pin(3'h3, 1'b1, 1'b1, 1'b0, 1'b0);
    st(sbc_pkg::SBC_OFF, 2'b00);
    pin(3'h2, 1'b1, 1'b1, 1'b0, 1'b0);
    req();
    st(sbc_pkg::SBC_PRECOND, 2'b10);
    pin(3'h3, 1'b1, 1'b1, 1'b0, 1'b0);
    st(sbc_pkg::SBC_OFF, 2'b00);
    chk("charge_fault_flag", 32'(fault), 32'h0);
    pin(3'h1, 1'b1, 1'b1, 1'b0, 1'b0);
    req();
    wr(sbc_pkg::ADDR_ALARM, 32'h0000_8000);
    st(sbc_pkg::SBC_OFF, 2'b00);
    chk("alarm_block_flag", 32'(alarm), 32'h1);
    pin(3'h4, 1'b1, 1'b1, 1'b0, 1'b0);
    st(sbc_pkg::SBC_RESET, 2'b00);
    pin(3'h1, 1'b1, 1'b1, 1'b0, 1'b0);
    // wait for wake-up: a write landing while still in reset is cleared
    st(sbc_pkg::SBC_WAKE, 2'b10);
    req();
    st(sbc_pkg::SBC_PRECOND, 2'b10);
    wr(sbc_pkg::ADDR_CONTROL, 32'h2);
    st(sbc_pkg::SBC_OFF, 2'b00);
    wr(sbc_pkg::ADDR_CONTROL, 32'h0);
    req();
    wr(sbc_pkg::ADDR_CONTROL, 32'h4);
    st(sbc_pkg::SBC_CAL, 2'b00);
    wr(sbc_pkg::ADDR_CONTROL, 32'h0);
    req();
    st(sbc_pkg::SBC_PRECOND, 2'b10);
    pin(3'h1, 1'b0, 1'b1, 1'b0, 1'b0);
    st(sbc_pkg::SBC_RESET, 2'b00);
    pin(3'h1, 1'b1, 1'b1, 1'b0, 1'b0);
    st(sbc_pkg::SBC_WAKE, 2'b10);
    req();
    pin(3'h1, 1'b1, 1'b0, 1'b0, 1'b0);
    st(sbc_pkg::SBC_RESET, 2'b00);
    results();
  end
endmodule
